// file: hdl/cbd_top.sv
`timescale 1ns/1ps
// Operation
// [R1] processor exposes 16 address lines, low byte shared with data
// [R2] address latch strobe asserted while address sits on shared lines
// [R3] low address byte latched on strobe, drives system low address bus
// [R4] data byte passes shared lines to system data bus via bidirectional buffer
// [R5] program store is two read-only devices of 4096 bytes
// [R6] selected program memory drives its byte onto the shared lines
// [R7] scratch store is two 256x4 devices paired into 256 bytes
// [R8] scratch addressed by latched low address, gated by read/write strobes
// [R9] supply failure asserts the non-maskable trap
// [R10] on trap, execution continues at power-down routine start
// [R11] switch-on reset starts the main program
// [R12] timing reference is a 5 MHz crystal clock
// [R13] four readouts, each four characters with own storage and drive
// [R14] readout character position chosen by system address
// [R15] readout characters are ASCII bytes from the data bus
// [R16] trigger-absent, run and remote lamps driven by dedicated signals
// [R17] display, select, gain and range lamps switched by addresses
// [R18] beam blanking output feeds the intensity amplifier
// [R19] decoders give mutually exclusive selects from upper address lines; display, lamp and blank selects here also decode the low address byte
module cbd_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_fail,
  input wire logic [cbd_pkg::ADDR_W-1:8] cpu_addr_hi,
  input wire logic [cbd_pkg::DATA_W-1:0] shared_low_bus_lines_in,
  output logic [cbd_pkg::DATA_W-1:0] shared_low_bus_lines_out,
  output logic shared_low_bus_lines_oe_n,
  input wire logic addr_strobe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [cbd_pkg::DATA_W-1:0] sys_data_in,
  output logic [cbd_pkg::DATA_W-1:0] sys_data_out,
  output logic sys_data_oe_n,
  output logic [cbd_pkg::ADDR_W-1:0] sys_addr,
  input wire cbd_pkg::cbd_direct_lamp_s direct_lamp_in,
  output cbd_pkg::cbd_direct_lamp_s direct_lamp_out,
  output logic [cbd_pkg::LAMP_COUNT-1:0] addressed_lamps,
  output logic [cbd_pkg::DISP_COUNT*cbd_pkg::DISP_CHARS*cbd_pkg::DATA_W-1:0] disp_chars,
  output logic beam_blank_drive,
  output logic cpu_reset,
  output logic cpu_trap,
  output logic [cbd_pkg::ADDR_W-1:0] cpu_vector,
  output logic xtal_clk,
  output cbd_pkg::cbd_sel_s chip_sel
);
  import cbd_pkg::*;

  function automatic cbd_sel_s decode(input logic [15:0] a);
    cbd_sel_s s;
    s = '0;
    if (a[15:12] == ROM0_REGION) begin
      s.rom0 = 1'b1;
    end else if (a[15:12] == ROM1_REGION) begin
      s.rom1 = 1'b1;
    end else if (a[15:8] == RAM_PAGE) begin
      s.ram = 1'b1;
    end else if (a[15:8] == PERIPH_PAGE) begin
      if (a[7:4] == DISP_BASE_LO[7:4]) s.disp = 1'b1;
      else if (a[7:4] == LAMP_BASE_LO[7:4]) s.lamp = 1'b1;
      else if (a[7:0] == BLANK_LO) s.blank = 1'b1;
    end
    return s; // [R19]
  endfunction : decode

  logic [7:0] addr_lo_r, addr_lo_nxt;
  logic [7:0] rom0 [ROM_DEPTH];
  logic [7:0] rom1 [ROM_DEPTH];
  logic [NIB_W-1:0] ram_lo_r [RAM_DEPTH];
  logic [NIB_W-1:0] ram_hi_r [RAM_DEPTH];
  logic [7:0] disp_r [DISP_COUNT*DISP_CHARS];
  logic [LAMP_COUNT-1:0] lamps_r, lamps_nxt;
  logic blank_r, blank_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_act_r, rd_act_nxt;
  logic wr_n_d_r;
  cbd_cpu_e st_r, st_nxt;
  logic [$clog2(POR_CYC+1)-1:0] por_r, por_nxt;
  logic [$clog2(XTAL_HALF+1)-1:0] xdiv_r, xdiv_nxt;
  logic xtal_r, xtal_nxt;
  logic [15:0] full_addr;
  cbd_sel_s sel;
  logic wr_pulse;

  // program contents are loaded by the image; zero-filled here
  always_comb begin
    for (int i = 0; i < ROM_DEPTH; i++) begin
      rom0[i] = 8'h00; // [R5]
      rom1[i] = 8'h00;
    end
  end

  // latch is transparent while the strobe is high, holds afterward
  always_comb begin
    addr_lo_nxt = addr_strobe ? shared_low_bus_lines_in : addr_lo_r; // [R2] [R3]
  end

  assign full_addr = {cpu_addr_hi, addr_strobe ? shared_low_bus_lines_in : addr_lo_r}; // [R1]
  assign sel = decode(full_addr);
  assign sys_addr = {cpu_addr_hi, addr_lo_r}; // [R3]
  assign chip_sel = sel;
  assign wr_pulse = !wr_n && wr_n_d_r && !addr_strobe;

  // read path; data only driven when strobe is low so address phase stays clean
  always_comb begin
    rd_act_nxt = !rd_n && !addr_strobe; // [R4]
    rd_data_nxt = sys_data_in;
    if (sel.rom0) rd_data_nxt = rom0[full_addr[11:0]]; // [R6]
    else if (sel.rom1) rd_data_nxt = rom1[full_addr[11:0]];
    else if (sel.ram) rd_data_nxt = {ram_hi_r[addr_lo_r], ram_lo_r[addr_lo_r]}; // [R7] [R8]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_lo_r <= 8'h00;
      rd_data_r <= 8'h00;
      rd_act_r <= 1'b0;
      wr_n_d_r <= 1'b1;
    end else begin
      addr_lo_r <= addr_lo_nxt;
      rd_data_r <= rd_data_nxt;
      rd_act_r <= rd_act_nxt;
      wr_n_d_r <= wr_n;
    end
  end

  assign shared_low_bus_lines_out = rd_data_r;
  assign shared_low_bus_lines_oe_n = !(rd_act_r && !rd_n && !addr_strobe); // [R4]
  assign sys_data_out = shared_low_bus_lines_in;
  assign sys_data_oe_n = !(!wr_n && !addr_strobe); // [R4]

  // memory and peripheral writes on the falling edge of the write strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DISP_COUNT*DISP_CHARS; i++) disp_r[i] <= 8'h20;
    end else if (wr_pulse && sel.disp) begin
      disp_r[addr_lo_r[3:0]] <= shared_low_bus_lines_in; // [R13] [R14] [R15]
    end
  end

  // scratch keeps contents through reset: it stands in for battery-backed storage
  always_ff @(posedge clk) begin
    if (wr_pulse && sel.ram && st_r == ST_RUN) begin
      ram_lo_r[addr_lo_r] <= shared_low_bus_lines_in[3:0]; // [R7] [R8]
      ram_hi_r[addr_lo_r] <= shared_low_bus_lines_in[7:4];
    end
  end

  always_comb begin
    lamps_nxt = lamps_r;
    blank_nxt = blank_r;
    if (wr_pulse && sel.lamp) lamps_nxt[addr_lo_r[2:0]] = shared_low_bus_lines_in[0]; // [R17]
    if (wr_pulse && sel.blank) blank_nxt = shared_low_bus_lines_in[0]; // [R18]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lamps_r <= '0;
      blank_r <= BLANK_RST[0];
    end else begin
      lamps_r <= lamps_nxt;
      blank_r <= blank_nxt;
    end
  end

  generate
    for (genvar g = 0; g < DISP_COUNT*DISP_CHARS; g++) begin : g_disp
      assign disp_chars[g*8 +: 8] = disp_r[g];
    end
  endgenerate

  assign addressed_lamps = lamps_r;
  assign beam_blank_drive = blank_r; // [R18]
  assign direct_lamp_out = direct_lamp_in; // [R16]

  // power-on and trap sequencing
  always_comb begin
    st_nxt = st_r;
    por_nxt = por_r;
    case (st_r)
      ST_RESET: begin
        if (por_r == '0) st_nxt = ST_RUN; // [R11]
        else por_nxt = por_r - 1'b1;
      end
      ST_RUN: begin
        if (supply_fail) st_nxt = ST_TRAP; // [R9]
      end
      ST_TRAP: begin
        if (!supply_fail) begin
          st_nxt = ST_RESET;
          por_nxt = ($clog2(POR_CYC+1))'(POR_CYC);
        end
      end
      default: st_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_RESET;
      por_r <= ($clog2(POR_CYC+1))'(POR_CYC);
    end else begin
      st_r <= st_nxt;
      por_r <= por_nxt;
    end
  end

  assign cpu_reset = (st_r == ST_RESET); // [R11]
  assign cpu_trap = (st_r == ST_TRAP); // [R9]
  assign cpu_vector = (st_r == ST_TRAP) ? PDOWN_START : MAIN_START; // [R10]

  // crystal reference derived from the system clock
  always_comb begin
    xtal_nxt = xtal_r;
    xdiv_nxt = xdiv_r + 1'b1;
    if (xdiv_r == ($clog2(XTAL_HALF+1))'(XTAL_HALF - 1)) begin
      xdiv_nxt = '0;
      xtal_nxt = !xtal_r; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xdiv_r <= '0;
      xtal_r <= 1'b0;
    end else begin
      xdiv_r <= xdiv_nxt;
      xtal_r <= xtal_nxt;
    end
  end

  assign xtal_clk = xtal_r;
endmodule : cbd_top

// file: hdl/cbd_pkg.sv
package cbd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ROM_DEPTH = 4096;
  localparam int RAM_DEPTH = 256;
  localparam int NIB_W = 4;
  localparam int DISP_COUNT = 4;
  localparam int DISP_CHARS = 4;
  localparam int LAMP_COUNT = 8;
  // memory map regions (upper address nibble or byte, low byte inside peripheral page)
  localparam logic [3:0] ROM0_REGION = 4'h0;
  localparam logic [3:0] ROM1_REGION = 4'h1;
  localparam logic [7:0] RAM_PAGE = 8'h40;
  localparam logic [7:0] PERIPH_PAGE = 8'h80;
  localparam logic [7:0] DISP_BASE_LO = 8'hA0;
  localparam logic [7:0] LAMP_BASE_LO = 8'hB0;
  localparam logic [7:0] BLANK_LO = 8'hC0;
  localparam logic [15:0] MAIN_START = 16'h0000;
  localparam logic [15:0] PDOWN_START = 16'h0024;
  localparam logic [7:0] BLANK_RST = 8'h01;
  localparam real XTAL_MHZ = 5.0;
  localparam real CLK_MHZ = 250.0;
  localparam int XTAL_HALF = int'(CLK_MHZ / XTAL_MHZ / 2.0);
  localparam int POR_NS = 1000;
  localparam int POR_CYC = POR_NS * 250 / 1000;

  typedef struct packed {
    logic rom0;
    logic rom1;
    logic ram;
    logic disp;
    logic lamp;
    logic blank;
  } cbd_sel_s;

  typedef struct packed {
    logic trigger_absent_lamp;
    logic acquisition_running_lamp;
    logic host_control_lamp;
  } cbd_direct_lamp_s;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_TRAP} cbd_cpu_e;
endpackage : cbd_pkg

// file: bench/cbd_top_monitor.sv
`timescale 1ns/1ps
module cbd_top_monitor
  import cbd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_fail,
  input wire logic [cbd_pkg::DATA_W-1:0] shared_low_bus_lines_in,
  input wire logic addr_strobe,
  input wire logic wr_n,
  input wire logic [cbd_pkg::DATA_W-1:0] sys_data_out,
  input wire logic sys_data_oe_n,
  input wire logic [cbd_pkg::ADDR_W-1:0] sys_addr,
  input wire logic [cbd_pkg::LAMP_COUNT-1:0] addressed_lamps,
  input wire logic beam_blank_drive,
  input wire logic cpu_reset,
  input wire logic cpu_trap,
  input wire logic [cbd_pkg::ADDR_W-1:0] cpu_vector,
  input wire logic xtal_clk,
  input wire cbd_pkg::cbd_sel_s chip_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [8:0] xc_r, xc_nxt, pc_r, pc_nxt;
  logic xl_r, seen_r, seen_nxt;
  // first divider half after reset is skipped: its phase is not pinned down
  always_comb begin
    xc_nxt = (reset || xtal_clk != xl_r) ? 9'h000 : xc_r + 9'h001;
    seen_nxt = !reset && (seen_r || xtal_clk != xl_r);
    pc_nxt = (reset || !cpu_reset) ? 9'h000 : pc_r + 9'h001;
  end
  always_ff @(posedge clk) begin
    xl_r <= xtal_clk;
    xc_r <= xc_nxt;
    seen_r <= seen_nxt;
    pc_r <= pc_nxt;
  end
  a_latch_capture: assert property (addr_strobe |=> sys_addr[7:0] == $past(shared_low_bus_lines_in))
    else $error("low address not latched");
  a_latch_hold: assert property (!addr_strobe && !$past(reset) |=> $stable(sys_addr[7:0]))
    else $error("latch moved without strobe");
  a_sel_excl: assert property ($onehot0(chip_sel))
    else $error("selects overlap");
  a_sel_decode: assert property ((!chip_sel.ram || sys_addr[15:8] == RAM_PAGE)
    && (!chip_sel.rom1 || sys_addr[15:12] == ROM1_REGION)) else $error("select off map");
  a_trap_entry: assert property (supply_fail && !cpu_reset |-> ##[0:2] cpu_trap && cpu_vector == PDOWN_START)
    else $error("trap not taken");
  a_por_len: assert property ($fell(cpu_reset) |-> pc_r >= POR_CYC - 1 && pc_r <= POR_CYC + 1)
    else $error("power-on reset length");
  a_xtal_half: assert property (seen_r && xtal_clk != xl_r |-> xc_r == XTAL_HALF - 1)
    else $error("crystal half period");
  a_reset_vals: assert property ($past(reset) |-> beam_blank_drive && addressed_lamps == 8'h00)
    else $error("reset outputs");
  a_wr_buffer: assert property (!wr_n && !addr_strobe |-> !sys_data_oe_n && sys_data_out == shared_low_bus_lines_in)
    else $error("write data not buffered");
  a_addr_phase: assert property (addr_strobe |-> sys_data_oe_n)
    else $error("data buffer on in address phase");
endmodule : cbd_top_monitor

bind cbd_top cbd_top_monitor u_cbd_top_monitor (.clk, .reset, .supply_fail, .shared_low_bus_lines_in,
  .addr_strobe, .wr_n, .sys_data_out, .sys_data_oe_n, .sys_addr, .addressed_lamps, .beam_blank_drive, .cpu_reset,
  .cpu_trap, .cpu_vector,
  .xtal_clk, .chip_sel);

// file: bench/cbd_cpu_model.sv
`timescale 1ns/1ps
module cbd_cpu_model (
  input wire logic clk,
  input wire logic [cbd_pkg::DATA_W-1:0] bus_out,
  input wire logic bus_oe_n,
  output logic [cbd_pkg::ADDR_W-1:8] addr_hi,
  output logic [cbd_pkg::DATA_W-1:0] bus_in,
  output logic strobe,
  output logic rd_n,
  output logic wr_n
);
  logic drv_r = 1'h0;
  logic [7:0] val_r = 8'h00;
  // released lines show the inverse of the last value, never a stale copy
  assign bus_in = !bus_oe_n ? bus_out : (drv_r ? val_r : ~val_r);
  initial begin
    addr_hi = 8'h00;
    strobe = 1'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
  end
  task automatic xfer(input logic [15:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr_hi <= a[15:8];
    val_r <= a[7:0];
    drv_r <= 1'h1;
    strobe <= 1'h1;
    @(posedge clk);
    strobe <= 1'h0;
    val_r <= d;
    drv_r <= wr;
    rd_n <= wr;
    wr_n <= !wr;
    @(posedge clk);
    @(posedge clk);
    q = bus_in;
    rd_n <= 1'h1;
    wr_n <= 1'h1;
    drv_r <= 1'h0;
  endtask : xfer
endmodule : cbd_cpu_model

// file: bench/cbd_top_test.sv
`timescale 1ns/1ps
module cbd_top_test;
  import cbd_pkg::*;
  logic clk, reset, supply_fail, addr_strobe, rd_n, wr_n, beam_blank_drive, cpu_reset, cpu_trap, xtal_clk;
  logic shared_low_bus_lines_oe_n, sys_data_oe_n;
  logic [7:0] cpu_addr_hi, shared_low_bus_lines_in, shared_low_bus_lines_out, sys_data_in, sys_data_out, q;
  logic [7:0] addressed_lamps;
  logic [15:0] sys_addr, cpu_vector;
  logic [127:0] disp_chars;
  cbd_direct_lamp_s direct_lamp_in, direct_lamp_out;
  cbd_sel_s chip_sel;
  int n_mismatch = 0;
  int compares = 0;
  cbd_top u_cbd_top (.clk, .reset, .supply_fail, .cpu_addr_hi, .shared_low_bus_lines_in, .shared_low_bus_lines_out,
    .shared_low_bus_lines_oe_n, .addr_strobe, .rd_n, .wr_n, .sys_data_in, .sys_data_out, .sys_data_oe_n, .sys_addr,
    .direct_lamp_in, .direct_lamp_out, .addressed_lamps, .disp_chars, .beam_blank_drive, .cpu_reset, .cpu_trap,
    .cpu_vector, .xtal_clk, .chip_sel);
  cbd_cpu_model u_cbd_cpu_model (.clk, .bus_out(shared_low_bus_lines_out), .bus_oe_n(shared_low_bus_lines_oe_n),
    .addr_hi(cpu_addr_hi), .bus_in(shared_low_bus_lines_in), .strobe(addr_strobe), .rd_n, .wr_n);
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic wait_lvl(ref logic s, input logic v);
    int i;
    for (i = 0; i < 600 && s !== v; i++) @(posedge clk);
    chk("wait", v, s);
    if (s !== v) summarize();
  endtask : wait_lvl
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_cbd_cpu_model.xfer(a, 1'h1, d, q);
  endtask : wr
  task automatic rdchk(input string n, input logic [15:0] a, input logic [7:0] e);
    u_cbd_cpu_model.xfer(a, 1'h0, 8'h00, q);
    chk(n, e, q);
  endtask : rdchk
  task automatic t_mem();
    wr(16'h4000, 8'hA5);
    wr(16'h40FF, 8'h3C);
    chk("sys_addr", 16'h40FF, sys_addr);
    rdchk("ram0", 16'h4000, 8'hA5);
    rdchk("ram1", 16'h40FF, 8'h3C);
    rdchk("rom", 16'h1FFF, 8'h00);
    @(posedge clk);
    sys_data_in <= 8'h96;
    rdchk("unmapped", 16'h9000, 8'h96);
  endtask : t_mem
  task automatic t_front();
    for (int i = 0; i < 16; i++) begin
      wr(16'h80A0 + 16'(i), 8'h30 + 8'(i));
      chk("char", 8'h30 + 8'(i), disp_chars[i*8+:8]);
    end
    for (int i = 0; i < 8; i++) wr(16'h80B0 + 16'(i), {7'h00, i[0]});
    chk("lamps", 16'h00AA, addressed_lamps);
    direct_lamp_in <= 3'h5;
    wr(16'h80C0, 8'h00);
    chk("direct", 3'h5, direct_lamp_out);
    chk("blank", 1'h0, beam_blank_drive);
  endtask : t_front
  task automatic t_trap();
    wr(16'h4010, 8'h5A);
    supply_fail <= 1'h1;
    wait_lvl(cpu_trap, 1'h1);
    chk("vector", PDOWN_START, cpu_vector);
    wr(16'h4010, 8'hFF);
    supply_fail <= 1'h0;
    wait_lvl(cpu_reset, 1'h1);
    wait_lvl(cpu_reset, 1'h0);
    rdchk("kept", 16'h4010, 8'h5A);
  endtask : t_trap
  initial begin
    reset = 1'h1;
    supply_fail = 1'h0;
    sys_data_in = 8'h00;
    direct_lamp_in = 3'h2;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    chk("char", 16'h0020, disp_chars[7:0]);
    chk("por", 1'h1, cpu_reset);
    wait_lvl(cpu_reset, 1'h0);
    chk("main_vec", MAIN_START, cpu_vector);
    t_mem();
    t_front();
    t_trap();
    summarize();
  end
endmodule : cbd_top_test
